// ===== src/ohi_dev.sv
// Purpose: display end of the host port: decode, capture, scan timing
// Assumes: all link pins asynchronous to sys_clk
// Notes:   pins pass three flops; a change stands once stages 2 and 3 agree
`timescale 1ns/1ns
`default_nettype none
`include "ohi_regs.svh"
// Overview of operation
// - select pins pick one of four modes
// - reset pin low reinitialises the controller
// - transfers only while chip select low
// - selector high marks byte as display data
// - selector low sends byte to command
// - 68 style: cycle while enable high
// - 68 style: direction high reads, low writes
// - 80 style: read strobe low drives data
// - 80 style: write strobe low captures data
// - parallel data lines are bidirectional
// - serial data on D1, clock on D0
// - host holds unused lines low
// - frame trigger output shows scan status
// - scan 256 columns by 64 rows
module ohi_dev
    import ohi_pkg::*;
#(
    parameter int ROWS = `OHI_ROWS,
    parameter int COLS = `OHI_COLS
)(
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic [7:0] tx_data,
    output logic            tx_take,
    output logic            rx_valid,
    output logic            rx_is_data,
    output logic [7:0]      rx_data,
    output logic [7:0]      cmd_reg,
    output logic            ctl_reset,
    output logic [1:0]      mode_out,
    output logic [$clog2(ROWS)-1:0] scan_row,
    output logic [$clog2(COLS)-1:0] scan_col,
    ohi_link_if.dev_mp      link
);
    localparam int RW = $clog2(ROWS);
    localparam int CW = $clog2(COLS);

    // ==========================================================
    // state
    typedef struct packed {
        ohi_pins_t   s1;
        ohi_pins_t   s2;
        ohi_pins_t   s3;
        ohi_pins_t   flt;
        ohi_mode_t   mode;
        logic [8:0]  shreg;
        logic [3:0]  bitcnt;
        logic [7:0]  rd_q;
        logic        drive;
        logic        take;
        logic        rx_valid;
        logic        rx_dc;
        logic [7:0]  rx_data;
        logic [7:0]  cmd;
        logic [RW-1:0] row;
        logic [CW-1:0] col;
        logic        frame;
    } ohi_dev_st_t;

    ohi_dev_st_t q;
    ohi_dev_st_t d;
    ohi_pins_t   raw;
    ohi_pins_t   nf;
    logic        rd_now;
    logic        rd_was;
    logic        wr_now;
    logic        wr_was;
    logic [3:0]  need;

    // ==========================================================
    // pin capture
    assign raw = '{bs_lo: link.protocol_select_lo,
                   bs_hi: link.protocol_select_hi,
                   rst_n: link.reset_n_input,
                   cs_n:  link.cs_n,
                   dc:    link.dc,
                   stb:   link.strobe,
                   dir:   link.dir,
                   d:     link.host_data_bus};

    // filtered view: a bit moves only when stages 2 and 3 agree
    assign nf = ohi_pins_t'((~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.flt));

    // ==========================================================
    // strobe decode per parallel style
    always_comb
    begin
        rd_now = 1'b0;
        rd_was = 1'b0;
        wr_now = 1'b0;
        wr_was = 1'b0;
        unique case (q.mode)
            OHI_PAR68:
            begin
                rd_now = !nf.cs_n && nf.stb && nf.dir;
                rd_was = !q.flt.cs_n && q.flt.stb && q.flt.dir;
                wr_now = !nf.cs_n && nf.stb && !nf.dir;
                wr_was = !q.flt.cs_n && q.flt.stb && !q.flt.dir;
            end
            OHI_PAR80:
            begin
                rd_now = !nf.cs_n && !nf.stb;
                rd_was = !q.flt.cs_n && !q.flt.stb;
                wr_now = !nf.cs_n && !nf.dir;
                wr_was = !q.flt.cs_n && !q.flt.dir;
            end
            OHI_SER3, OHI_SER4:
            begin
                rd_now = 1'b0;
                rd_was = 1'b0;
                wr_now = 1'b0;
                wr_was = 1'b0;
            end
        endcase
        need = (q.mode == OHI_SER3) ? 4'(`OHI_SER3_BITS) : 4'(`OHI_SER4_BITS);
    end

    // ==========================================================
    // next state
    always_comb
    begin
        d = q;
        d.take = 1'b0;
        d.rx_valid = 1'b0;
        d.s1 = raw;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.flt = nf;
        d.mode = ohi_mode_f(nf.bs_lo, nf.bs_hi);
        if (!nf.rst_n)
        begin
            // controller back to its initial state
            d.shreg = '0;
            d.bitcnt = 4'h0;
            d.drive = 1'b0;
            d.rd_q = 8'h00;
            d.cmd = 8'h00;
            d.row = '0;
            d.col = '0;
            d.frame = 1'b0;
        end
        else
        begin
            // panel scan: each row one sixty-fourth of the frame
            if (q.col == CW'(COLS - 1))
            begin
                d.col = '0;
                d.row = (q.row == RW'(ROWS - 1)) ? '0 : q.row + RW'(1);
            end
            else
            begin
                d.col = q.col + CW'(1);
            end
            d.frame = (d.row == '0);
            if (nf.cs_n)
            begin
                // deselect drops any partial serial byte
                d.bitcnt = 4'h0;
                d.drive = 1'b0;
            end
            else if (ohi_is_serial_f(q.mode))
            begin
                if (nf.d[0] && !q.flt.d[0])
                begin
                    d.shreg = {q.shreg[7:0], nf.d[1]};
                    d.bitcnt = q.bitcnt + 4'h1;
                    if (d.bitcnt == need)
                    begin
                        d.bitcnt = 4'h0;
                        d.rx_valid = 1'b1;
                        d.rx_data = d.shreg[7:0];
                        d.rx_dc = (q.mode == OHI_SER3) ? d.shreg[8] : nf.dc;
                    end
                end
            end
            else
            begin
                // read data loaded at strobe start, held till its end
                if (rd_now && !rd_was)
                begin
                    d.rd_q = tx_data;
                    d.take = 1'b1;
                    d.drive = 1'b1;
                end
                else if (!rd_now)
                begin
                    d.drive = 1'b0;
                end
                // write taken as its strobe closes
                if (wr_was && !wr_now)
                begin
                    d.rx_valid = 1'b1;
                    d.rx_data = q.flt.d;
                    d.rx_dc = q.flt.dc;
                end
            end
            // command bytes also land in the command register
            if (d.rx_valid && !d.rx_dc)
            begin
                d.cmd = d.rx_data;
            end
        end
    end

    // ==========================================================
    // registers; ce low freezes everything
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q <= '0;
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs
    assign link.dev_do = q.rd_q;
    assign link.dev_oe_n = !q.drive;
    assign link.frame_trigger_out = q.frame;
    assign tx_take = q.take;
    assign rx_valid = q.rx_valid;
    assign rx_is_data = q.rx_dc;
    assign rx_data = q.rx_data;
    assign cmd_reg = q.cmd;
    assign ctl_reset = !q.flt.rst_n;
    assign mode_out = q.mode;
    assign scan_row = q.row;
    assign scan_col = q.col;
endmodule // ohi_dev
`default_nettype wire

// ===== src/ohi_host.sv
// Purpose: controller end that writes and reads the display port
// Assumes: one command at a time; link pins leave through flops, save the select pins (straight from cfg) and 80 style strobe and dir gating
// Notes:   serial modes are write only, reads there are dropped
`timescale 1ns/1ns
`default_nettype none
`include "ohi_regs.svh"
module ohi_host
    import ohi_pkg::*;
#(
    parameter int RESET_NS = `OHI_RESET_NS
)(
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic       cfg_bs_lo,
    input  wire logic       cfg_bs_hi,
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire logic       cmd_read,
    input  wire logic       cmd_dc,
    input  wire logic [7:0] cmd_data,
    output logic            rsp_valid,
    output logic [7:0]      rsp_data,
    ohi_link_if.host_mp     link
);
    // ==========================================================
    // timing
    localparam int CLK = `OHI_CLK_NS;
    localparam int HALF_CYC = `OHI_SCLK_HALF_NS / CLK;
    localparam int SETUP_CYC = (`OHI_SETUP_NS + CLK - 1) / CLK;
    localparam int STB_CYC = (`OHI_STROBE_NS + CLK - 1) / CLK;
    localparam int HOLD_CYC = (`OHI_HOLD_NS + CLK - 1) / CLK;
    localparam int RST_CYC = (RESET_NS + CLK - 1) / CLK;

    typedef struct packed {
        ohi_hstate_t st;
        logic [15:0] rstcnt;
        logic [7:0]  cnt;
        logic [3:0]  bitcnt;
        logic [8:0]  shreg;
        logic        read;
        logic [7:0]  wdata;
        logic        sclk;
        logic        cs_n;
        logic        dc;
        logic        stb;
        logic        dir;
        logic [7:0]  dout;
        logic        oe_n;
        logic        rst_n;
        logic        rsp_valid;
        logic [7:0]  rsp_data;
        logic [7:0]  s1;
        logic [7:0]  s2;
        logic [7:0]  s3;
        logic [7:0]  flt;
    } ohi_host_st_t;

    ohi_host_st_t q;
    ohi_host_st_t d;
    ohi_mode_t    mode;
    logic         ser;
    logic         take;

    assign mode = ohi_mode_f(cfg_bs_lo, cfg_bs_hi);
    assign ser = ohi_is_serial_f(mode);
    assign cmd_ready = (q.st == OHI_H_IDLE) && q.rst_n;
    assign take = cmd_valid && cmd_ready;

    // ==========================================================
    // sequencer
    always_comb
    begin
        d = q;
        d.rsp_valid = 1'b0;
        d.s1 = link.host_data_bus;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.flt = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.flt);
        // display reset held low after our own reset
        if (q.rstcnt != 16'(RST_CYC))
        begin
            d.rstcnt = q.rstcnt + 16'h0001;
        end
        d.rst_n = (d.rstcnt == 16'(RST_CYC));
        if (q.cnt != 8'h00)
        begin
            d.cnt = q.cnt - 8'h01;
        end
        unique case (q.st)
            OHI_H_IDLE:
            begin
                if (take && !(ser && cmd_read))
                begin
                    d.cs_n = 1'b0;
                    d.dc = cmd_dc;
                    d.read = cmd_read;
                    d.wdata = cmd_data;
                    d.dir = (mode == OHI_PAR68) && cmd_read;
                    d.shreg = (mode == OHI_SER3) ? {cmd_dc, cmd_data} : {cmd_data, 1'b0};
                    d.bitcnt = 4'h0;
                    d.cnt = 8'(SETUP_CYC);
                    d.st = OHI_H_SETUP;
                end
            end
            OHI_H_SETUP:
            begin
                if (q.cnt == 8'h00)
                begin
                    d.st = OHI_H_STROBE;
                    d.cnt = ser ? 8'(HALF_CYC) : 8'(STB_CYC);
                    if (mode == OHI_PAR68)
                    begin
                        d.stb = 1'b1;
                    end
                    else if (mode == OHI_PAR80)
                    begin
                        d.stb = !q.read;
                        d.dir = q.read;
                    end
                end
            end
            OHI_H_STROBE:
            begin
                if (q.cnt == 8'h00 && ser)
                begin
                    // serial clock on D0, data on D1, rising edge samples
                    d.cnt = 8'(HALF_CYC);
                    d.sclk = !q.sclk;
                    if (q.sclk)
                    begin
                        d.shreg = {q.shreg[7:0], 1'b0};
                        d.bitcnt = q.bitcnt + 4'h1;
                        if (d.bitcnt == ((mode == OHI_SER3) ? 4'(`OHI_SER3_BITS)
                                                             : 4'(`OHI_SER4_BITS)))
                        begin
                            d.st = OHI_H_HOLD;
                            d.cnt = 8'(HOLD_CYC);
                        end
                    end
                end
                else if (q.cnt == 8'h00)
                begin
                    // sample read data while the strobe still stands
                    d.rsp_valid = q.read;
                    d.rsp_data = q.flt;
                    d.stb = (mode == OHI_PAR80);
                    d.dir = (mode == OHI_PAR80) || q.dir;
                    d.st = OHI_H_HOLD;
                    d.cnt = 8'(HOLD_CYC);
                end
            end
            OHI_H_HOLD:
            begin
                if (q.cnt == 8'h00)
                begin
                    d.cs_n = 1'b1;
                    d.read = 1'b0;
                    d.dir = (mode == OHI_PAR80);
                    d.st = OHI_H_IDLE;
                end
            end
        endcase
        // unused lines low, D2 too; released only on parallel reads
        d.dout = ser ? {6'h00, d.shreg[8], d.sclk} : (d.read ? 8'h00 : d.wdata);
        d.oe_n = d.read;
    end

    // idle levels: strobes inactive, serial strobes tied low
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q <= '0;
            q.cs_n <= 1'b1;
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    assign link.protocol_select_lo = cfg_bs_lo;
    assign link.protocol_select_hi = cfg_bs_hi;
    assign link.reset_n_input = q.rst_n;
    assign link.cs_n = q.cs_n;
    assign link.dc = q.dc;
    assign link.strobe = q.stb || ((mode == OHI_PAR80) && q.st != OHI_H_STROBE);
    assign link.dir = q.dir || ((mode == OHI_PAR80) && q.st != OHI_H_STROBE);
    assign link.host_do = q.dout;
    assign link.host_oe_n = q.oe_n;
    assign rsp_valid = q.rsp_valid;
    assign rsp_data = q.rsp_data;
endmodule // ohi_host
`default_nettype wire

// ===== src/ohi_link_if.sv
// Purpose: pin bundle between host and display ends
// Assumes: both ends on their own clocks
// Notes:   data lines resolved here from the two enables
`timescale 1ns/1ns
`default_nettype none
interface ohi_link_if;
    logic       protocol_select_lo;
    logic       protocol_select_hi;
    logic       reset_n_input;
    logic       cs_n;
    logic       dc;
    logic       strobe;
    logic       dir;
    logic [7:0] host_do;
    logic       host_oe_n;
    logic [7:0] dev_do;
    logic       dev_oe_n;
    logic [7:0] host_data_bus;
    logic       frame_trigger_out;

    // host wins a clash; undriven lines read low
    assign host_data_bus = !host_oe_n ? host_do : (!dev_oe_n ? dev_do : 8'h00);

    modport dev_mp (
        input  protocol_select_lo, protocol_select_hi, reset_n_input,
        input  cs_n, dc, strobe, dir, host_data_bus,
        output dev_do, dev_oe_n, frame_trigger_out
    );
    modport host_mp (
        output protocol_select_lo, protocol_select_hi, reset_n_input,
        output cs_n, dc, strobe, dir, host_do, host_oe_n,
        input  host_data_bus
    );
endinterface
`default_nettype wire

// ===== src/ohi_pkg.sv
// Purpose: shared types of the display host port
// Assumes: nothing
// Notes:   mode code is {protocol_select_lo, protocol_select_hi}
package ohi_pkg;
    typedef enum logic [1:0] {
        OHI_SER4  = 2'h0,
        OHI_PAR80 = 2'h1,
        OHI_SER3  = 2'h2,
        OHI_PAR68 = 2'h3
    } ohi_mode_t;

    typedef enum logic [1:0] {
        OHI_H_IDLE   = 2'h0,
        OHI_H_SETUP  = 2'h1,
        OHI_H_STROBE = 2'h3,
        OHI_H_HOLD   = 2'h2
    } ohi_hstate_t;

    // pins as seen by the display side
    typedef struct packed {
        logic       bs_lo;
        logic       bs_hi;
        logic       rst_n;
        logic       cs_n;
        logic       dc;
        logic       stb;
        logic       dir;
        logic [7:0] d;
    } ohi_pins_t;

    function automatic ohi_mode_t ohi_mode_f(input logic lo, input logic hi);
        return ohi_mode_t'({lo, hi});
    endfunction

    function automatic logic ohi_is_serial_f(input ohi_mode_t m);
        return (m == OHI_SER3) || (m == OHI_SER4);
    endfunction
endpackage

// ===== src/ohi_regs.svh
// Purpose: timing and geometry constants for the display host port
// Assumes: system clock period given in ns below
// Notes:   counts in cycles are derived where used
`ifndef OHI_REGS_SVH
`define OHI_REGS_SVH
`define OHI_CLK_NS        20
`define OHI_SCLK_HALF_NS  80
`define OHI_SETUP_NS      80
`define OHI_STROBE_NS     320
`define OHI_HOLD_NS       80
`define OHI_RESET_NS      2000
`define OHI_ROWS          64
`define OHI_COLS          256
`define OHI_SER3_BITS     9
`define OHI_SER4_BITS     8
`endif

// ===== test/ohi_link_chk.sv
// Purpose: assertions on the pins between host end and display end
// Assumes: link signals arrive as plain inputs on the host clock
// Notes:   frame checks wait for two frame starts after a display reset
`timescale 1ns/1ns
`default_nettype none
module ohi_link_chk
    import ohi_pkg::*;
#(
    parameter int ROWS = 64,
    parameter int COLS = 256
)(
    input wire logic       sys_clk,
    input wire logic       arst_n,
    input wire logic       protocol_select_lo,
    input wire logic       protocol_select_hi,
    input wire logic       reset_n_input,
    input wire logic       cs_n,
    input wire logic       strobe,
    input wire logic       dir,
    input wire logic       host_oe_n,
    input wire logic       dev_oe_n,
    input wire logic [7:0] host_data_bus,
    input wire logic       frame_trigger_out
);
    logic        p68;
    logic        p80;
    logic        ser;
    logic        fr_q;
    logic [31:0] hi_cnt_q;
    logic [31:0] per_cnt_q;
    logic [1:0]  rises_q;

    // mode decode from the select pins
    assign p68 = protocol_select_lo & protocol_select_hi;
    assign p80 = !protocol_select_lo & protocol_select_hi;
    assign ser = !protocol_select_hi;

    // frame counters; the first frame after reset may be cut short
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fr_q      <= 1'b0;
            hi_cnt_q  <= 32'h0;
            per_cnt_q <= 32'h0;
            rises_q   <= 2'h0;
        end
        else
        begin
            fr_q      <= frame_trigger_out;
            hi_cnt_q  <= frame_trigger_out ? hi_cnt_q + 32'h1 : 32'h0;
            per_cnt_q <= (frame_trigger_out && !fr_q) ? 32'h1 : per_cnt_q + 32'h1;
            if (frame_trigger_out && !fr_q && rises_q != 2'h3)
                rises_q <= rises_q + 2'h1;
            if (!reset_n_input)
                rises_q <= 2'h0;
        end
    end

    // =====================================================
    // assertions
    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    a_bus_no_clash: assert property ((!cs_n && reset_n_input) |-> (host_oe_n || dev_oe_n))
        else $error("both ends drive the data bus");
    a_dev_cs_quiet: assert property (cs_n [*7] |-> dev_oe_n)
        else $error("display drives while unselected");
    a_dev_rst_quiet: assert property (!reset_n_input [*7] |-> dev_oe_n)
        else $error("display drives while in reset");
    a_ser_no_drive: assert property (ser [*7] |-> dev_oe_n)
        else $error("display drives in serial mode");
    a_ser_unused_low: assert property (ser |-> host_data_bus[7:2] == 6'h00)
        else $error("unused data lines not low");
    a_p68_write_quiet: assert property ((p68 && !dir) [*7] |-> dev_oe_n)
        else $error("display drives on a 68 write");
    a_p68_read_drive: assert property
        ((p68 && !cs_n && strobe && dir && reset_n_input) [*7] |-> !dev_oe_n)
        else $error("display silent on a 68 read");
    a_p80_rd_idle: assert property ((p80 && strobe) [*7] |-> dev_oe_n)
        else $error("display drives without read strobe");
    a_p80_read_drive: assert property
        ((p80 && !cs_n && !strobe && reset_n_input) [*7] |-> !dev_oe_n)
        else $error("display silent on an 80 read");
    a_frame_period: assert property
        ((frame_trigger_out && !fr_q && rises_q >= 2'h2) |-> per_cnt_q == ROWS * COLS)
        else $error("frame period wrong");
    a_frame_width: assert property
        ((!frame_trigger_out && fr_q && rises_q >= 2'h2) |-> hi_cnt_q == COLS)
        else $error("frame trigger width wrong");
endmodule // ohi_link_chk
`default_nettype wire

// ===== test/testbench.sv
// Purpose: host end and display end joined, driven from their user sides
// Assumes: small scan size and short display reset to keep the run brief
// Notes:   every mode change goes through a reset, the select pins never move live
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import ohi_pkg::*;
    localparam int ROWS   = 4;
    localparam int COLS   = 8;
    localparam int WD_CYC = 20000;
    typedef struct packed {
        logic [1:0] mode;
        logic       rd;
        logic       dc;
        logic [7:0] data;
    } ohi_tb_row_t;
    logic                      sys_clk, arst_n, cfg_bs_lo, cfg_bs_hi, seen;
    logic                      cmd_valid, cmd_ready, cmd_read, cmd_dc, rsp_valid;
    logic                      tx_take, rx_valid, rx_is_data, ctl_reset;
    logic [7:0]                cmd_data, tx_data, rsp_data, rx_data, cmd_reg, last_cmd;
    logic [1:0]                mode_out;
    logic [$clog2(ROWS)-1:0]   scan_row;
    logic [$clog2(COLS)-1:0]   scan_col;
    logic [8:0]                rx_q[$];
    logic [7:0]                rsp_q[$];
    logic [7:0]                cnt;
    int                        failures, samples_checked, n;
    ohi_tb_row_t               rows[10];

    ohi_link_if link_i();
    ohi_host #(.RESET_NS(100)) ohi_host_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .ce(1'b1), .cfg_bs_lo(cfg_bs_lo),
        .cfg_bs_hi(cfg_bs_hi), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_read(cmd_read), .cmd_dc(cmd_dc), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .link(link_i));
    ohi_dev #(.ROWS(ROWS), .COLS(COLS)) ohi_dev_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .ce(1'b1), .tx_data(tx_data),
        .tx_take(tx_take), .rx_valid(rx_valid), .rx_is_data(rx_is_data),
        .rx_data(rx_data), .cmd_reg(cmd_reg), .ctl_reset(ctl_reset), .mode_out(mode_out),
        .scan_row(scan_row), .scan_col(scan_col), .link(link_i));
    ohi_link_chk #(.ROWS(ROWS), .COLS(COLS)) ohi_link_chk_i (
        .sys_clk(sys_clk), .arst_n(arst_n),
        .protocol_select_lo(link_i.protocol_select_lo),
        .protocol_select_hi(link_i.protocol_select_hi),
        .reset_n_input(link_i.reset_n_input), .cs_n(link_i.cs_n),
        .strobe(link_i.strobe), .dir(link_i.dir), .host_oe_n(link_i.host_oe_n),
        .dev_oe_n(link_i.dev_oe_n), .host_data_bus(link_i.host_data_bus),
        .frame_trigger_out(link_i.frame_trigger_out));

    // 50 MHz system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // collect one-cycle result pulses so no pulse is missed while waiting
    always @(negedge sys_clk)
    begin
        if (rx_valid === 1'b1)
            rx_q.push_back({rx_is_data, rx_data});
        if (rsp_valid === 1'b1)
            rsp_q.push_back(rsp_data);
    end

    // =====================================================
    // compare and drive tasks
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // hold the request until the edge that sees cmd_ready high
    task automatic send(input logic rd, input logic dc, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        for (int i = 0; i < 400 && cmd_ready !== 1'b1; i++)
        begin
            @(posedge sys_clk);
            #1;
        end
        cmd_valid = 1'b1;
        cmd_read  = rd;
        cmd_dc    = dc;
        cmd_data  = d;
        tx_data   = d;
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b0;
    endtask

    task automatic expect_rx(input logic dc, input logic [7:0] d);
        logic [8:0] got;
        for (int i = 0; i < 400 && rx_q.size() == 0; i++)
            @(posedge sys_clk);
        got = (rx_q.size() > 0) ? rx_q.pop_front() : 9'bx;
        chk_bit(got[8], dc);
        chk_byte(got[7:0], d);
    endtask

    task automatic expect_rsp(input logic [7:0] d);
        logic [7:0] got;
        for (int i = 0; i < 400 && rsp_q.size() == 0; i++)
            @(posedge sys_clk);
        got = (rsp_q.size() > 0) ? rsp_q.pop_front() : 8'bx;
        chk_byte(got, d);
    endtask

    // reset both ends; select pins only move while reset is held
    task automatic do_reset(input logic [1:0] m);
        @(posedge sys_clk);
        #1;
        arst_n = 1'b0;
        {cfg_bs_lo, cfg_bs_hi} = m;
        last_cmd = 8'h00;
        repeat (4) @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
    endtask

    task automatic test_done();
        if (failures == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // =====================================================
    // main sequence
    initial
    begin
        arst_n = 1'b0;
        {cmd_valid, cmd_read, cmd_dc, cfg_bs_lo, cfg_bs_hi} = 5'h00;
        cmd_data = 8'h00;
        tx_data = 8'h00;
        failures = 0;
        samples_checked = 0;
        rows = '{'{OHI_SER3, 1'b0, 1'b0, 8'hA5}, '{OHI_SER3, 1'b0, 1'b1, 8'h3C},
                 '{OHI_SER4, 1'b0, 1'b0, 8'h81}, '{OHI_SER4, 1'b0, 1'b1, 8'h7E},
                 '{OHI_PAR68, 1'b0, 1'b0, 8'h5A}, '{OHI_PAR68, 1'b0, 1'b1, 8'hC3},
                 '{OHI_PAR68, 1'b1, 1'b1, 8'h96}, '{OHI_PAR80, 1'b0, 1'b0, 8'h0F},
                 '{OHI_PAR80, 1'b0, 1'b1, 8'hF0}, '{OHI_PAR80, 1'b1, 1'b1, 8'h69}};
        do_reset(rows[0].mode);
        // table pass over every mode, writes of both kinds and parallel reads
        for (n = 0; n < 10; n++)
        begin
            if (n > 0 && rows[n].mode != rows[n-1].mode)
                do_reset(rows[n].mode);
            send(rows[n].rd, rows[n].dc, rows[n].data);
            if (rows[n].rd)
                expect_rsp(rows[n].data);
            else
                expect_rx(rows[n].dc, rows[n].data);
            if (!rows[n].rd && !rows[n].dc)
                last_cmd = rows[n].data;
            chk_byte(cmd_reg, last_cmd);
            chk_byte({6'h00, mode_out}, {6'h00, rows[n].mode});
        end
        // display reset pulse seen, command register cleared
        do_reset(OHI_PAR80);
        seen = 1'b0;
        repeat (20)
        begin
            @(posedge sys_clk);
            seen = seen | (ctl_reset === 1'b1);
        end
        chk_bit(seen, 1'b1);
        chk_bit(ctl_reset, 1'b0);
        chk_byte(cmd_reg, 8'h00);
        // back to back writes keep order and kind
        send(1'b0, 1'b0, 8'h3A);
        send(1'b0, 1'b1, 8'h5C);
        expect_rx(1'b0, 8'h3A);
        expect_rx(1'b1, 8'h5C);
        // reset in mid write: nothing may land
        send(1'b0, 1'b0, 8'hE7);
        repeat (6) @(posedge sys_clk);
        do_reset(OHI_PAR68);
        repeat (100) @(posedge sys_clk);
        chk_bit(rx_q.size() == 0, 1'b1);
        chk_byte(cmd_reg, 8'h00);
        send(1'b1, 1'b0, 8'hB4);
        expect_rsp(8'hB4);
        // serial reads are dropped, writes still pass
        do_reset(OHI_SER4);
        send(1'b1, 1'b1, 8'h77);
        repeat (150) @(posedge sys_clk);
        chk_bit(rsp_q.size() == 0, 1'b1);
        send(1'b0, 1'b0, 8'hC6);
        expect_rx(1'b0, 8'hC6);
        // two whole frames hold exactly two rows of trigger
        cnt = 8'h00;
        repeat (2 * ROWS * COLS)
        begin
            @(posedge sys_clk);
            #1;
            cnt = cnt + {7'h00, link_i.frame_trigger_out === 1'b1};
        end
        chk_byte(cnt, 8'(2 * COLS));
        test_done();
    end

    // watchdog cuts a hang short
    initial
    begin
        repeat (WD_CYC) @(posedge sys_clk);
        failures++;
        test_done();
    end
endmodule // testbench
`default_nettype wire
